// [hdl/cec_misc0.sv]
// Corrected-error counter syndrome register of one error record
// Operation
// - No standard format: syndrome in 31:0, bits 63:32 read zero
// - 16-bit single: count 46:32, flag 47
// - 8-bit single: count 38:32, flag 39
// - Single counter counts every corrected error
// - Wrap flag sets on wrap, stays set
// - Flag writes may upset status overflow flag
// - Cold reset any value (here RSTN loads zero); recovery reset keeps
// - 16-bit dual: other 63/62:48, repeat 47/46:32
// - 8-bit dual: other 47/46:40, repeat 39/38:32
// - Repeat counts first error, then matching ones
// - Other counts every error repeat misses
// - Dual formats: corrected errors are countable
// - Injection present: parts writable when not valid
// - Counters readable and writable by software
// - Error-specific syndrome ignores writes while valid
// - Format field picks none, 8-bit, 16-bit
// - Dual option gives repeat plus other counter
// - Writing zero to syndrome makes record quiet
`timescale 1ns/1ps
`include "cec_misc0_cfg.svh"

module cec_misc0
  import cec_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  input  wire logic [2:0]             FMT_SEL,
  input  wire logic                   DUAL_OPT,
  input  wire logic                   REC_COUNTABLE,
  input  wire logic                   VALID_FLAG,
  input  wire logic                   ERR_EVT,
  input  wire logic [1:0]             ERR_CLASS,
  input  wire logic [`CEC_SYND_W-1:0] ERR_SYND,
  input  wire logic                   REG_WR,
  input  wire logic [63:0]            REG_WDATA,
  output logic      [63:0]            REG_RDATA,
  output logic                        WRAP_EVT
);

  // ----------------------------------------------------------------
  // Layout selection
  // ----------------------------------------------------------------
  cec_layout_t           layout;     // Active register layout
  logic                  narrow;     // 8-bit formats
  logic                  dual;       // Repeat plus other counter
  logic                  std_fmt;    // Standard counters present
  logic                  countable;  // Class may be counted
  logic                  cnt_ev;     // Countable event this cycle
  logic                  match;      // Syndrome equals captured one
  logic [1:0]            inc_vec;    // Increment per counter
  logic [1:0]            wr_en_vec;  // Software write per counter
  logic [`CEC_CNT_W-1:0] wr_cnt [2]; // Written count per counter
  logic [1:0]            wr_flg;     // Written flag per counter
  logic [`CEC_CNT_W-1:0] cnt [2];    // Count per counter
  logic [1:0]            flg;        // Wrap flag per counter
  logic [1:0]            wrap_vec;   // Wrap pulse per counter
  logic [`CEC_SYND_W-1:0] synd_reg;  // Captured syndrome
  logic                  held_reg;   // A syndrome is captured
  logic                  synd_wr_ok; // Syndrome field writable
  logic [63:0]           rd_next;    // Packed read value

  // Decode feature fields; reserved codes act as no counter
  always_comb begin
    layout = CEC_LAY_NONE;
    if (REC_COUNTABLE) begin
      case (FMT_SEL)
        `CEC_FMT_8BIT:  layout = DUAL_OPT ? CEC_LAY_D8 : CEC_LAY_W8;
        `CEC_FMT_16BIT: layout = DUAL_OPT ? CEC_LAY_D16 : CEC_LAY_W16;
        default:        layout = CEC_LAY_NONE;
      endcase
    end
  end

  assign narrow  = (layout == CEC_LAY_W8) || (layout == CEC_LAY_D8);
  assign dual    = (layout == CEC_LAY_D8) || (layout == CEC_LAY_D16);
  assign std_fmt = (layout != CEC_LAY_NONE);

  // ----------------------------------------------------------------
  // Event qualification and counter steering
  // ----------------------------------------------------------------
  // Corrected always counts; others by build choice
  always_comb begin
    case (cec_err_class_t'(ERR_CLASS))
      CEC_ERR_CORR:   countable = 1'b1;
      CEC_ERR_DEFER:  countable = `CEC_COUNT_DEFERRED;
      CEC_ERR_UNCORR: countable = `CEC_COUNT_UNCORR;
      default:        countable = 1'b0;
    endcase
  end

  assign cnt_ev = ERR_EVT && countable;
  assign match  = held_reg && (ERR_SYND == synd_reg);

  // Primary/repeat counter or other counter, never both
  assign inc_vec[0] = std_fmt && cnt_ev && (!dual || !held_reg || match);
  assign inc_vec[1] = dual && cnt_ev && held_reg && !match;

  // ----------------------------------------------------------------
  // Software write unpacking
  // ----------------------------------------------------------------
  // Counters always writable so software can reset them
  always_comb begin
    wr_en_vec = {dual && REG_WR, std_fmt && REG_WR};
    wr_cnt[0] = `CEC_CNT_RST;
    wr_cnt[1] = `CEC_CNT_RST;
    wr_flg    = 2'b00;
    case (layout)
      CEC_LAY_W16, CEC_LAY_D16: begin
        wr_cnt[0] = REG_WDATA[`CEC_W16_CNT_HI:`CEC_CNT_LO];
        wr_flg[0] = REG_WDATA[`CEC_W16_FLAG];
        wr_cnt[1] = REG_WDATA[`CEC_D16_OCNT_HI:`CEC_D16_OCNT_LO];
        wr_flg[1] = REG_WDATA[`CEC_D16_OFLAG];
      end
      CEC_LAY_W8, CEC_LAY_D8: begin
        wr_cnt[0] = {8'h00, REG_WDATA[`CEC_W8_CNT_HI:`CEC_CNT_LO]};
        wr_flg[0] = REG_WDATA[`CEC_W8_FLAG];
        wr_cnt[1] = {8'h00, REG_WDATA[`CEC_D8_OCNT_HI:`CEC_D8_OCNT_LO]};
        wr_flg[1] = REG_WDATA[`CEC_D8_OFLAG];
      end
      default: begin
        wr_flg = 2'b00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Counter instances
  // ----------------------------------------------------------------
  // Index 0 is the primary or repeat counter, index 1 the other
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cnt
      cec_wrap_cnt u_cnt (
        .clk     (CLK),
        .rst_n   (RSTN),
        .narrow  (narrow),
        .inc     (inc_vec[gi]),
        .wr_en   (wr_en_vec[gi]),
        .wr_cnt  (wr_cnt[gi]),
        .wr_flag (wr_flg[gi]),
        .cnt_q   (cnt[gi]),
        .flag_q  (flg[gi]),
        .wrap    (wrap_vec[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Syndrome capture
  // ----------------------------------------------------------------
  // Error-specific syndrome locked while the record is valid
  assign synd_wr_ok = REG_WR && !VALID_FLAG;

  // Capture beats a same-cycle write; zero write frees the capture
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      synd_reg <= `CEC_SYND_RST;
      held_reg <= 1'b0;
    end else if (cnt_ev && (!dual || !held_reg)) begin
      synd_reg <= ERR_SYND;
      held_reg <= 1'b1;
    end else if (synd_wr_ok) begin
      synd_reg <= REG_WDATA[`CEC_SYND_W-1:0];
      held_reg <= (REG_WDATA[`CEC_SYND_W-1:0] != `CEC_SYND_RST);
    end
  end

  // ----------------------------------------------------------------
  // Read path and wrap report
  // ----------------------------------------------------------------
  // Pack fields by layout; unused bits read zero
  always_comb begin
    rd_next = {32'h0000_0000, synd_reg};
    case (layout)
      CEC_LAY_W16: begin
        rd_next[`CEC_W16_FLAG] = flg[0];
        rd_next[`CEC_W16_CNT_HI:`CEC_CNT_LO] = cnt[0];
      end
      CEC_LAY_W8: begin
        rd_next[`CEC_W8_FLAG] = flg[0];
        rd_next[`CEC_W8_CNT_HI:`CEC_CNT_LO] = cnt[0][6:0];
      end
      CEC_LAY_D16: begin
        rd_next[`CEC_D16_OFLAG] = flg[1];
        rd_next[`CEC_D16_OCNT_HI:`CEC_D16_OCNT_LO] = cnt[1];
        rd_next[`CEC_W16_FLAG] = flg[0];
        rd_next[`CEC_W16_CNT_HI:`CEC_CNT_LO] = cnt[0];
      end
      CEC_LAY_D8: begin
        rd_next[`CEC_D8_OFLAG] = flg[1];
        rd_next[`CEC_D8_OCNT_HI:`CEC_D8_OCNT_LO] = cnt[1][6:0];
        rd_next[`CEC_W8_FLAG] = flg[0];
        rd_next[`CEC_W8_CNT_HI:`CEC_CNT_LO] = cnt[0][6:0];
      end
      default: begin
        rd_next = {32'h0000_0000, synd_reg};
      end
    endcase
  end

  // Registered read data
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      REG_RDATA <= `CEC_RDATA_RST;
    end else begin
      REG_RDATA <= rd_next;
    end
  end

  // Hardware wraps only; software flag writes do not report here
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      WRAP_EVT <= 1'b0;
    end else begin
      WRAP_EVT <= |wrap_vec;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_single_count: assert property (@(posedge CLK) disable iff (!RSTN)
    (std_fmt && !dual && cnt_ev && !REG_WR) |=>
      (cnt[0] == (($past(cnt[0]) + 15'h0001) & (narrow ? `CEC_MASK_NARROW : `CEC_MASK_WIDE))))
    else $error("single counter missed an error");

  chk_repeat_first: assert property (@(posedge CLK) disable iff (!RSTN)
    (dual && cnt_ev && !held_reg && !REG_WR) |=> (held_reg && synd_reg == $past(ERR_SYND) &&
      cnt[0] == (($past(cnt[0]) + 15'h0001) & (narrow ? `CEC_MASK_NARROW : `CEC_MASK_WIDE))))
    else $error("first error not taken by repeat counter");

  chk_other_miss: assert property (@(posedge CLK) disable iff (!RSTN)
    (dual && cnt_ev && held_reg && !match && !REG_WR) |=> ($stable(cnt[0]) && $changed(cnt[1])))
    else $error("mismatched error not taken by other counter");

  chk_count_once: assert property (@(posedge CLK) disable iff (!RSTN)
    (dual && cnt_ev && !REG_WR) |=> ($changed(cnt[0]) != $changed(cnt[1])))
    else $error("error counted zero or two times");

  // Report flop loads from the same wrap term as the flag, so both rise together
  chk_wrap_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    (inc_vec[0] && !REG_WR && (cnt[0] == (narrow ? `CEC_MASK_NARROW : `CEC_MASK_WIDE))) |=>
      (flg[0] && cnt[0] == `CEC_CNT_RST && WRAP_EVT))
    else $error("wrap did not set flag and report");

  // Any set wrap flag survives until software writes the register
  chk_flag_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
    ((|flg) && !REG_WR) |=> ((flg & $past(flg)) == $past(flg)))
    else $error("wrap flag cleared without a write");

  chk_synd_lock: assert property (@(posedge CLK) disable iff (!RSTN)
    (REG_WR && VALID_FLAG && !cnt_ev) |=> $stable(synd_reg))
    else $error("syndrome changed by write while valid");

  chk_zero_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    (synd_wr_ok && !cnt_ev && REG_WDATA[31:0] == `CEC_SYND_RST) |=> (!held_reg && synd_reg == `CEC_SYND_RST))
    else $error("zero write did not quiesce syndrome");

  chk_none_idle: assert property (@(posedge CLK) disable iff (!RSTN)
    (layout == CEC_LAY_NONE) |=> (REG_RDATA[63:32] == 32'h0000_0000))
    else $error("counter bits visible without standard format");

  chk_d16_map: assert property (@(posedge CLK) disable iff (!RSTN)
    (layout == CEC_LAY_D16) |=> (REG_RDATA[62:48] == $past(cnt[1]) && REG_RDATA[63] == $past(flg[1])))
    else $error("other counter misplaced in 16-bit dual layout");

  chk_w8_map: assert property (@(posedge CLK) disable iff (!RSTN)
    (layout == CEC_LAY_W8) |=> (REG_RDATA[39] == $past(flg[0]) && REG_RDATA[38:32] == $past(cnt[0][6:0])))
    else $error("counter misplaced in 8-bit layout");

endmodule

// [hdl/cec_misc0_cfg.svh]
// Constants for the corrected-error counter syndrome register
`ifndef CEC_MISC0_CFG_SVH
`define CEC_MISC0_CFG_SVH

// Counter-format feature codes
`define CEC_FMT_NONE      3'h0
`define CEC_FMT_8BIT      3'h2
`define CEC_FMT_16BIT     3'h4

// Field widths and masks
`define CEC_CNT_W         15
`define CEC_SYND_W        32
`define CEC_MASK_WIDE     15'h7fff
`define CEC_MASK_NARROW   15'h007f

// Field positions, single-counter layouts
`define CEC_W16_FLAG      47
`define CEC_W16_CNT_HI    46
`define CEC_W8_FLAG       39
`define CEC_W8_CNT_HI     38
`define CEC_CNT_LO        32

// Field positions, dual-counter layouts
`define CEC_D16_OFLAG     63
`define CEC_D16_OCNT_HI   62
`define CEC_D16_OCNT_LO   48
`define CEC_D8_OFLAG      47
`define CEC_D8_OCNT_HI    46
`define CEC_D8_OCNT_LO    40

// Reset values
`define CEC_CNT_RST       15'h0000
`define CEC_SYND_RST      32'h0000_0000
`define CEC_RDATA_RST     64'h0000_0000_0000_0000

// Whether deferred and uncorrected errors are countable
`define CEC_COUNT_DEFERRED 1'b0
`define CEC_COUNT_UNCORR   1'b0

`endif

// [hdl/cec_pkg.sv]
// Types for the corrected-error counter syndrome register
package cec_pkg;

  // Register layout selected by the node features
  typedef enum logic [2:0] {
    CEC_LAY_NONE = 3'b000,
    CEC_LAY_W8   = 3'b001,
    CEC_LAY_W16  = 3'b010,
    CEC_LAY_D8   = 3'b011,
    CEC_LAY_D16  = 3'b100
  } cec_layout_t;

  // Class of a reported error
  typedef enum logic [1:0] {
    CEC_ERR_CORR   = 2'b00,
    CEC_ERR_DEFER  = 2'b01,
    CEC_ERR_UNCORR = 2'b10,
    CEC_ERR_RSVD   = 2'b11
  } cec_err_class_t;

endpackage

// [hdl/cec_wrap_cnt.sv]
// One wrapping error counter with its sticky wrap flag
`timescale 1ns/1ps
`include "cec_misc0_cfg.svh"

module cec_wrap_cnt
  import cec_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   narrow,
  input  wire logic                   inc,
  input  wire logic                   wr_en,
  input  wire logic [`CEC_CNT_W-1:0]  wr_cnt,
  input  wire logic                   wr_flag,
  output logic      [`CEC_CNT_W-1:0]  cnt_q,
  output logic                        flag_q,
  output logic                        wrap
);

  logic [`CEC_CNT_W-1:0] mask;      // Active counter width
  logic [`CEC_CNT_W-1:0] base;      // Value before increment
  logic [`CEC_CNT_W-1:0] cnt_next;  // Next count
  logic                  flag_next; // Next wrap flag

  // Software write first, then the event increments on top of it
  always_comb begin
    mask      = narrow ? `CEC_MASK_NARROW : `CEC_MASK_WIDE;
    base      = wr_en ? (wr_cnt & mask) : (cnt_q & mask);
    wrap      = inc && (base == mask);
    cnt_next  = inc ? ((base + 15'h0001) & mask) : base;
    flag_next = wrap | (wr_en ? wr_flag : flag_q);
  end

  // Counter state; defined value on cold reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= `CEC_CNT_RST;
      flag_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_next;
      flag_q <= flag_next;
    end
  end

endmodule

// [bench/cec_err_src.sv]
// Error-detection source model that feeds one error record
`timescale 1ns/1ps

module cec_err_src (
  input  wire logic        clk,
  output logic             err_evt,
  output logic [1:0]       err_class,
  output logic [31:0]      err_synd
);
  // Idle values at time zero
  initial begin
    err_evt   = 1'b0;
    err_class = 2'h0;
    err_synd  = 32'h0000_0000;
  end

  // One-cycle report; class and syndrome scrambled once released
  task automatic report(input logic [1:0] cls, input logic [31:0] sy);
    @(posedge clk);
    err_evt   <= 1'b1;
    err_class <= cls;
    err_synd  <= sy;
    @(posedge clk);
    err_evt   <= 1'b0;
    err_class <= ~cls;
    err_synd  <= ~sy;
  endtask
endmodule

// [bench/corrected_error_counter_misc_bench.sv]
// Self-checking bench for the corrected-error counter syndrome register
`timescale 1ns/1ps

module corrected_error_counter_misc_bench
  import cec_pkg::*;
;
  logic        clk, rstn, dual, cnt_ok, valid, wr_en, wrap_evt;
  logic [2:0]  fmt;
  logic [63:0] wdata, rdata;
  logic        evt;
  logic [1:0]  cls;
  logic [31:0] synd;
  int          fails, checked, wraps, cycles;

  // Time-zero values, clock
  initial begin
    clk = 1'b0; rstn = 1'b0; fmt = 3'h4; dual = 1'b0; cnt_ok = 1'b1;
    valid = 1'b0; wr_en = 1'b0; wdata = 64'h0;
    fails = 0; checked = 0; wraps = 0; cycles = 0;
  end
  always #5 clk = ~clk;

  cec_misc0 u_cec_misc0 (.CLK(clk), .RSTN(rstn), .FMT_SEL(fmt), .DUAL_OPT(dual), .REC_COUNTABLE(cnt_ok),
    .VALID_FLAG(valid), .ERR_EVT(evt), .ERR_CLASS(cls), .ERR_SYND(synd), .REG_WR(wr_en),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .WRAP_EVT(wrap_evt));
  cec_err_src u_cec_err_src (.clk(clk), .err_evt(evt), .err_class(cls), .err_synd(synd));

  // Wrap pulse counter and hang guard
  always @(posedge clk) begin
    if (wrap_evt === 1'b1) wraps++;
    cycles++;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end

  // Expected register image from field values
  function automatic logic [63:0] ev(input logic w8, dl, of, input logic [14:0] oc,
                                     input logic rf, input logic [14:0] rc, input logic [31:0] sy);
    logic [63:0] v;
    v = {32'h0, sy};
    if (w8) begin
      v[39] = rf; v[38:32] = rc[6:0];
      if (dl) begin v[47] = of; v[46:40] = oc[6:0]; end
    end else begin
      v[47] = rf; v[46:32] = rc;
      if (dl) begin v[63] = of; v[62:48] = oc; end
    end
    return v;
  endfunction

  // Compare and count
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Full-word write, one cycle
  task automatic wr(input logic [63:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Let the read value catch up
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Node features, then clear the record
  task automatic cfg(input logic [2:0] f, input logic d, input logic c);
    @(posedge clk);
    fmt <= f; dual <= d; cnt_ok <= c;
    wr(64'h0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    logic [2:0] f;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    settle();
    check("reset image", rdata, 64'h0);
    // No-counter layouts: format none, reserved, record not countable
    for (int i = 0; i < 3; i++) begin
      f = (i == 1) ? 3'h3 : ((i == 0) ? 3'h0 : 3'h4);
      cfg(f, 1'b0, i != 2);
      u_cec_err_src.report(CEC_ERR_CORR, 32'h1234_5670 + i);
      settle();
      check("syndrome only", rdata, {32'h0, 32'h1234_5670 + i});
    end
    wr(64'hffff_ffff_ffff_ffff);
    settle();
    check("upper bits", rdata, {32'h0, 32'hffff_ffff});
    wr(64'h0);
    settle();
    check("quiet", rdata, 64'h0);
    $display("test none done");
    // Wide single counter
    cfg(3'h4, 1'b0, 1'b1);
    for (int c = 1; c < 4; c++) u_cec_err_src.report(c[1:0], 32'h0bad_0000);
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00a1);
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00a1);
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00b2);
    settle();
    check("w16 count", rdata, ev(0, 0, 0, 0, 0, 15'h3, 32'hb2));
    wr({16'h0, 1'b0, 15'h7ffe, 32'h0});
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00c3);
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00c3);
    settle();
    check("w16 wrap", rdata, ev(0, 0, 0, 0, 1, 15'h0, 32'hc3));
    check("wrap pulses", 64'(wraps), 64'h1);
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00c3);
    settle();
    check("w16 sticky", rdata, ev(0, 0, 0, 0, 1, 15'h1, 32'hc3));
    @(posedge clk);
    valid <= 1'b1;
    wr({16'h0, 1'b0, 15'h0005, 32'hdead_beef});
    settle();
    check("w16 valid write", rdata, ev(0, 0, 0, 0, 0, 15'h5, 32'hc3));
    @(posedge clk);
    valid <= 1'b0;
    $display("test w16 done");
    // Narrow single counter
    cfg(3'h2, 1'b0, 1'b1);
    wr({16'hffff, 8'hff, 1'b0, 7'h7f, 32'h0});
    u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_00d4);
    settle();
    check("w8 wrap", rdata, ev(1, 0, 0, 0, 1, 15'h0, 32'hd4));
    check("wrap pulses", 64'(wraps), 64'h2);
    $display("test w8 done");
    // Dual counters, wide then narrow
    for (int k = 0; k < 2; k++) begin
      cfg(k ? 3'h2 : 3'h4, 1'b1, 1'b1);
      u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_0aaa);
      u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_0aaa);
      u_cec_err_src.report(CEC_ERR_CORR, 32'h0000_0bbb);
      u_cec_err_src.report(CEC_ERR_DEFER, 32'h0000_0bbb);
      settle();
      check("dual counts", rdata, ev(k, 1, 0, 15'h1, 0, 15'h2, 32'haaa));
    end
    $display("test dual done");
    // Cold reset in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    settle();
    check("cold reset", rdata, 64'h0);
    $display("test reset done");
    stop_test();
  end
endmodule
